// >>> hdl/serial_eeprom_bus_slave.sv
`timescale 1ns/10ps
module serial_eeprom_bus_slave
  import eeprom_slave_pkg::*;
#(
  parameter int ADDR_W = ADDR_W_DEFAULT,
  parameter int PAGE_W = PAGE_W_DEFAULT,
  parameter int T_WR   = T_WR_CYCLES
) (
  input  wire logic        sys_clk,
  input  wire logic        nrst,
  input  wire logic        scl_in,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe,
  input  wire logic        write_protect,
  input  wire logic        chip_select_pin_0,
  input  wire logic        chip_select_pin_1,
  input  wire logic        chip_select_pin_2,
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest
);

  localparam int PAGE_N = 2 ** PAGE_W;
  localparam int MEM_N  = 2 ** ADDR_W;

  logic [1:0]        scl_meta_reg, sda_meta_reg;
  logic              scl_s_reg, sda_s_reg, scl_d_reg, sda_d_reg;
  logic [3:0]        pin_meta_reg, pin_s_reg;
  link_state_e       state_reg, ack_next_reg;
  logic [3:0]        bit_cnt_reg;
  logic [7:0]        shift_reg, tx_reg;
  logic [2:0]        dev_hi_reg;
  logic [ADDR_W-1:0] ptr_reg;
  logic              pending_reg, busy_reg;
  logic [31:0]       wr_cnt_reg, ctrl_reg;
  logic [7:0]        mem [MEM_N];
  logic [7:0]        page_buf [PAGE_N];
  logic [PAGE_N-1:0] page_mask_reg;
  logic              scl_rise, scl_fall, start_det, stop_det, byte_done;
  logic              protect, buf_we, commit, addr_hit;
  logic [10:0]       full_addr;

  // Fixed type nibble; used select positions compare with the pins.
  function automatic logic dev_match(input logic [7:0] b, input logic [2:0] sel);
    int hi;
    logic ok;
    hi = (ADDR_W > 8) ? ADDR_W - 8 : 0;
    ok = (b[7:4] == DEV_TYPE_CODE);
    for (int i = 0; i < 3; i++)
    begin
      if (i >= hi && b[i+1] != sel[i])
        ok = 1'b0;
    end
    return ok;
  endfunction : dev_match

  // Three-stage synchronisers on scl and sda, two on the pins; edges are taken from the settled stages only.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      scl_meta_reg <= 2'h3;
      sda_meta_reg <= 2'h3;
      scl_s_reg    <= 1'b1;
      sda_s_reg    <= 1'b1;
      scl_d_reg    <= 1'b1;
      sda_d_reg    <= 1'b1;
      pin_meta_reg <= 4'h0;
      pin_s_reg    <= 4'h0;
    end
    else
    begin
      scl_meta_reg <= {scl_meta_reg[0], scl_in};
      sda_meta_reg <= {sda_meta_reg[0], sda_in};
      scl_s_reg    <= scl_meta_reg[1];
      sda_s_reg    <= sda_meta_reg[1];
      scl_d_reg    <= scl_s_reg;
      sda_d_reg    <= sda_s_reg;
      pin_meta_reg <= {write_protect, chip_select_pin_2, chip_select_pin_1, chip_select_pin_0};
      pin_s_reg    <= pin_meta_reg;
    end
  end

  assign scl_rise  = scl_s_reg && !scl_d_reg;
  assign scl_fall  = !scl_s_reg && scl_d_reg;
  assign start_det = scl_s_reg && scl_d_reg && !sda_s_reg && sda_d_reg;
  assign stop_det  = scl_s_reg && scl_d_reg && sda_s_reg && !sda_d_reg;
  assign byte_done = scl_fall && (bit_cnt_reg == BITS_PER_BYTE);
  assign protect   = pin_s_reg[3] || ctrl_reg[CTRL_PROTECT];
  assign addr_hit  = dev_match(shift_reg, pin_s_reg[2:0]);
  assign buf_we    = (state_reg == ST_WDATA) && byte_done && !protect;
  // One commit for the whole page.
  assign commit    = stop_det && pending_reg && !busy_reg;
  assign full_addr = {dev_hi_reg, shift_reg};

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state_reg    <= ST_IDLE;
      ack_next_reg <= ST_IDLE;
      bit_cnt_reg  <= 4'h0;
      shift_reg    <= 8'h00;
      tx_reg       <= 8'h00;
      dev_hi_reg   <= 3'h0;
      ptr_reg      <= '0;
      pending_reg  <= 1'b0;
      sda_oe       <= 1'b0;
    end
    else if (start_det)
    begin
      // A busy device stays deaf, so polling gets no acknowledge.
      state_reg   <= busy_reg ? ST_IDLE : ST_DEV;
      bit_cnt_reg <= 4'h0;
      sda_oe      <= 1'b0;
    end
    else if (stop_det)
    begin
      state_reg   <= ST_IDLE;
      sda_oe      <= 1'b0;
      pending_reg <= 1'b0;
    end
    else
    begin
      case (state_reg)
        ST_DEV, ST_WADDR, ST_WDATA:
        begin
          if (scl_rise)
          begin
            shift_reg   <= {shift_reg[6:0], sda_s_reg};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end
          else if (byte_done)
          begin
            // Acknowledge a matching address, the byte address and each data byte written while unprotected.
            sda_oe       <= 1'b1;
            state_reg    <= ST_ACK;
            ack_next_reg <= ST_WDATA;
            if (state_reg == ST_DEV)
            begin
              dev_hi_reg   <= shift_reg[3:1];
              ack_next_reg <= shift_reg[0] ? ST_RDATA : ST_WADDR;
              if (!addr_hit)
              begin
                sda_oe    <= 1'b0;
                state_reg <= ST_IDLE;
              end
              else if (shift_reg[0])
              begin
                // Direction bit one selects reading from the pointer.
                tx_reg  <= mem[ptr_reg];
                ptr_reg <= ADDR_W'(ptr_reg + 1'b1);
              end
            end
            else if (state_reg == ST_WADDR)
            begin
              // Byte address with high bits from the slave address.
              ptr_reg <= ADDR_W'(full_addr);
            end
            else if (protect)
            begin
              // Any data byte refused while protected.
              sda_oe    <= 1'b0;
              state_reg <= ST_IDLE;
            end
            else
            begin
              // Only the page offset advances; it wraps inside the page.
              ptr_reg     <= {ptr_reg[ADDR_W-1:PAGE_W], ptr_reg[PAGE_W-1:0] + 1'b1};
              pending_reg <= 1'b1;
            end
          end
        end
        ST_ACK:
        begin
          if (scl_fall)
          begin
            bit_cnt_reg <= 4'h0;
            state_reg   <= ack_next_reg;
            sda_oe      <= (ack_next_reg == ST_RDATA) ? !tx_reg[7] : 1'b0;
          end
        end
        ST_RDATA:
        begin
          if (scl_rise)
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          else if (byte_done)
          begin
            // Release the line for the master's acknowledge.
            sda_oe    <= 1'b0;
            state_reg <= ST_RACK;
          end
          else if (scl_fall)
            sda_oe <= !tx_reg[3'(4'h7 - bit_cnt_reg)];
        end
        ST_RACK:
        begin
          // Another byte per acknowledge, none after a refusal.
          if (scl_rise && sda_s_reg)
            state_reg <= ST_IDLE;
          else if (scl_fall)
          begin
            // Full-width increment wraps past the top location.
            tx_reg      <= mem[ptr_reg];
            ptr_reg     <= ADDR_W'(ptr_reg + 1'b1);
            bit_cnt_reg <= 4'h0;
            sda_oe      <= !mem[ptr_reg][7];
            state_reg   <= ST_RDATA;
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  // The page buffer keeps its own offsets so overrun bytes simply overwrite.
  always_ff @(posedge sys_clk)
  begin
    if (buf_we)
      page_buf[ptr_reg[PAGE_W-1:0]] <= shift_reg;
    if (commit)
    begin
      for (int i = 0; i < PAGE_N; i++)
      begin
        if (page_mask_reg[i])
          mem[{ptr_reg[ADDR_W-1:PAGE_W], PAGE_W'(i)}] <= page_buf[i];
      end
    end
  end

  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      page_mask_reg <= '0;
    else if (start_det || commit)
      page_mask_reg <= '0;
    // Overrun lands on an already marked offset.
    else if (buf_we)
      page_mask_reg[ptr_reg[PAGE_W-1:0]] <= 1'b1;
  end

  // Programming timer; the bus stays deaf while it runs.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      busy_reg   <= 1'b0;
      wr_cnt_reg <= 32'h0;
    end
    else if (commit)
    begin
      busy_reg   <= 1'b1;
      wr_cnt_reg <= 32'(T_WR - 1);
    end
    else if (busy_reg)
    begin
      if (wr_cnt_reg == 32'h0)
        busy_reg <= 1'b0;
      else
        wr_cnt_reg <= wr_cnt_reg - 32'h1;
    end
  end

  // Open-drain data: the output level is always low, only the enable moves.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      sda_out <= 1'b0;
    else
      sda_out <= 1'b0;
  end

  // Avalon slave: every access answers one cycle after it is presented.
  // Writes land on the edge where the master sees waitrequest low, never earlier.
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
    begin
      avs_waitrequest <= 1'b1;
      avs_readdata    <= 32'h0;
      ctrl_reg        <= CTRL_RESET;
    end
    else if ((avs_read || avs_write) && avs_waitrequest)
    begin
      avs_waitrequest <= 1'b0;
      avs_readdata    <= 32'h0;
      if (avs_read && avs_address == REG_CTRL)
        avs_readdata <= ctrl_reg & 32'h1;
      if (avs_read && avs_address == REG_STATUS)
        avs_readdata <= (32'(ptr_reg) << STATUS_PTR_LSB) | (32'(pin_s_reg[3]) << STATUS_WP)
                        | (32'(busy_reg) << STATUS_BUSY);
    end
    else
    begin
      avs_waitrequest <= 1'b1;
      if (avs_write && !avs_waitrequest && avs_address == REG_CTRL)
        ctrl_reg <= avs_writedata;
    end
  end

  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!nrst);

  logic [31:0] busy_len_reg;
  always_ff @(posedge sys_clk or negedge nrst)
  begin
    if (!nrst)
      busy_len_reg <= 32'h0;
    else
      busy_len_reg <= busy_reg ? busy_len_reg + 32'h1 : 32'h0;
  end

  sequence nack_seen;
    state_reg == ST_RACK && scl_rise && sda_s_reg && !start_det && !stop_det;
  endsequence

  ack_held_a : assert property (state_reg == ST_ACK |-> sda_oe)
    else $error("acknowledge not driven in ninth clock");
  dev_ack_a : assert property (state_reg == ST_DEV && byte_done && addr_hit && !start_det && !stop_det
    |=> sda_oe && state_reg == ST_ACK)
    else $error("matching address not acknowledged");
  rack_release_a : assert property (state_reg == ST_RACK |-> !sda_oe)
    else $error("line held during master acknowledge");
  nack_stop_a : assert property (nack_seen |=> state_reg == ST_IDLE && !sda_oe)
    else $error("sending continued after refusal");
  commit_busy_a : assert property (commit |=> busy_reg)
    else $error("program cycle not started");
  busy_deaf_a : assert property (busy_reg && start_det |=> state_reg == ST_IDLE [*2])
    else $error("busy device answered");
  protect_noack_a : assert property (state_reg == ST_WDATA && byte_done && protect && !start_det && !stop_det
    |=> !sda_oe && !pending_reg)
    else $error("protected byte acknowledged");
  page_wrap_a : assert property (buf_we && !start_det && !stop_det |=>
    ptr_reg[ADDR_W-1:PAGE_W] == $past(ptr_reg[ADDR_W-1:PAGE_W])
    && ptr_reg[PAGE_W-1:0] == PAGE_W'($past(ptr_reg[PAGE_W-1:0]) + 1'b1))
    else $error("page offset step wrong");
  read_inc_a : assert property (state_reg == ST_DEV && byte_done && addr_hit && shift_reg[0]
    && !start_det && !stop_det |=> ptr_reg == ADDR_W'($past(ptr_reg) + 1'b1))
    else $error("pointer not advanced on read");
  busy_len_a : assert property (busy_len_reg <= 32'(T_WR))
    else $error("program cycle too long");

endmodule : serial_eeprom_bus_slave

// >>> hdl/eeprom_slave_pkg.sv
package eeprom_slave_pkg;

  // Fixed upper nibble of the slave address byte.
  localparam logic [3:0] DEV_TYPE_CODE   = 4'hA;
  localparam int         CLK_HZ          = 100_000_000;
  localparam int         T_WR_MS         = 10;
  localparam int         T_WR_CYCLES     = T_WR_MS * (CLK_HZ / 1000);
  localparam int         ADDR_W_DEFAULT  = 8;
  localparam int         PAGE_W_DEFAULT  = 4;

  localparam logic [3:0]  REG_CTRL        = 4'h0;
  localparam logic [3:0]  REG_STATUS      = 4'h4;
  localparam int          CTRL_PROTECT    = 0;
  localparam logic [31:0] CTRL_RESET      = 32'h0000_0000;
  localparam int          STATUS_BUSY     = 0;
  localparam int          STATUS_WP       = 1;
  localparam int          STATUS_PTR_LSB  = 16;
  localparam logic [3:0]  BITS_PER_BYTE   = 4'h8;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_DEV,
    ST_WADDR,
    ST_WDATA,
    ST_ACK,
    ST_RDATA,
    ST_RACK
  } link_state_e;

endpackage : eeprom_slave_pkg

// >>> testbench/eeprom_bus_master_model.sv
`timescale 1ns/10ps
module eeprom_bus_master_model (
  input  wire logic sys_clk,
  input  wire logic sda_wire,
  output logic      scl_out,
  output logic      sda_level
);
  // The clock stands high between frames and the data line has a pull-up, so release means 1.
  initial
  begin
    scl_out   = 1'b1;
    sda_level = 1'b1;
  end
  task automatic q();
    repeat (4) @(posedge sys_clk);
  endtask : q
  task automatic start();
    q();
    sda_level <= 1'b1;
    q();
    scl_out <= 1'b1;
    q();
    sda_level <= 1'b0;
    q();
    scl_out <= 1'b0;
  endtask : start
  task automatic stop();
    q();
    sda_level <= 1'b0;
    q();
    scl_out <= 1'b1;
    q();
    sda_level <= 1'b1;
    q();
  endtask : stop
  task automatic clk_bit(input logic b, output logic r);
    q();
    sda_level <= b;
    q();
    scl_out <= 1'b1;
    q();
    r = sda_wire;
    q();
    scl_out <= 1'b0;
  endtask : clk_bit
  task automatic send_byte(input logic [7:0] d, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(d[i], r);
    clk_bit(1'b1, r);
    ack = !r;
  endtask : send_byte
  task automatic recv_byte(input logic more, output logic [7:0] d);
    logic r;
    for (int i = 7; i >= 0; i--)
      clk_bit(1'b1, d[i]);
    clk_bit(!more, r);
  endtask : recv_byte
endmodule : eeprom_bus_master_model

// >>> testbench/serial_eeprom_bus_slave_bench.sv
`timescale 1ns/10ps
module serial_eeprom_bus_slave_bench;
  import eeprom_slave_pkg::*;
  logic        sys_clk = 1'b0;
  logic        nrst = 1'b0;
  logic        scl, sda_level, sda_out, sda_oe, write_protect = 1'b0, avs_waitrequest;
  logic [2:0]  sel = 3'h0;
  logic [3:0]  avs_address = 4'h0;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rng = 32'h1AFD;
  wire         sda_wire = sda_level & !(sda_oe & !sda_out);
  int          err_total = 0, compares = 0, ptr = 0;
  int          mem [256];

  serial_eeprom_bus_slave #(.T_WR(200)) dut (
    .sys_clk(sys_clk), .nrst(nrst), .scl_in(scl), .sda_in(sda_wire), .sda_out(sda_out), .sda_oe(sda_oe),
    .write_protect(write_protect), .chip_select_pin_0(sel[0]), .chip_select_pin_1(sel[1]),
    .chip_select_pin_2(sel[2]), .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  eeprom_bus_master_model m (.sys_clk(sys_clk), .sda_wire(sda_wire), .scl_out(scl), .sda_level(sda_level));

  initial
  begin
    forever #5 sys_clk = !sys_clk;
  end
  function automatic logic [31:0] xs();
    rng = rng ^ (rng << 13);
    rng = rng ^ (rng >> 17);
    rng = rng ^ (rng << 5);
    return rng;
  endfunction : xs
  task automatic finish_test();
    if (err_total == 0 && compares > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask : finish_test
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    compares++;
    if (g !== e)
    begin
      $display("mismatch %s expected %h seen %h", n, e, g);
      err_total++;
    end
  endtask : chk
  // Waitrequest is sampled at rising edges only; read data is taken at the edge where it is low.
  task automatic av(input logic w, input logic [3:0] a, input logic [31:0] d, output logic [31:0] r);
    int n;
    n = 0;
    avs_address   <= a;
    avs_write     <= w;
    avs_read      <= !w;
    avs_writedata <= d;
    do
    begin
      @(posedge sys_clk);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    r = avs_readdata;
    avs_write <= 1'b0;
    avs_read  <= 1'b0;
    @(posedge sys_clk);
    if (n >= 50)
      chk("bus answer", 1, 0);
  endtask : av
  task automatic dev(input logic rw, input logic [2:0] s, output logic k);
    m.start();
    m.send_byte({DEV_TYPE_CODE, s, rw}, k);
  endtask : dev
  task automatic wr(input int a, input int n, input logic prot);
    logic        k;
    logic [7:0]  d;
    logic [31:0] r;
    int          i;
    dev(1'b0, sel, k);
    chk("write select ack", 1, k);
    m.send_byte(a[7:0], k);
    chk("byte address ack", 1, k);
    for (i = 0; i < n; i++)
    begin
      d = 8'(xs());
      m.send_byte(d, k);
      chk("data ack", !prot, k);
      if (prot)
        break;
      mem[a] = d;
      a = (a & 240) | ((a + 1) & 15);
    end
    m.stop();
    if (prot)
      return;
    ptr = a;
    av(1'b0, REG_STATUS, 32'h0, r);
    chk("busy flag", 1, r[STATUS_BUSY]);
    dev(1'b0, sel, k);
    m.stop();
    chk("busy poll", 0, k);
    i = 0;
    do
    begin
      dev(1'b0, sel, k);
      m.stop();
      i++;
    end while (!k && i < 40);
    chk("poll ack", 1, k);
  endtask : wr
  task automatic rd(input int a, input int n, input logic cur);
    logic       k;
    logic [7:0] d;
    if (cur)
      a = ptr;
    else
    begin
      dev(1'b0, sel, k);
      m.send_byte(a[7:0], k);
      chk("dummy address ack", 1, k);
    end
    dev(1'b1, sel, k);
    chk("read select ack", 1, k);
    for (int i = 0; i < n; i++)
    begin
      m.recv_byte(i < n - 1, d);
      chk("read data", mem[a], d);
      a = (a + 1) % 256;
    end
    m.stop();
    ptr = a;
  endtask : rd

  initial
  begin
    logic        k;
    logic [31:0] r;
    repeat (8) @(posedge sys_clk);
    nrst <= 1'b1;
    sel  <= 3'(xs());
    repeat (8) @(posedge sys_clk);
    av(1'b0, 4'h8, 32'h0, r);
    chk("unmapped read", 0, r);
    av(1'b0, REG_STATUS, 32'h0, r);
    chk("status after reset", 0, r);
    dev(1'b0, sel ^ 3'h1, k);
    m.stop();
    chk("foreign select", 0, k);
    wr(240, 16, 1'b0);
    wr(0, 16, 1'b0);
    wr(16, 1, 1'b0);
    wr(46, 18, 1'b0);
    rd(0, 1, 1'b1);
    rd(252, 8, 1'b0);
    rd(32, 16, 1'b0);
    for (int p = 0; p < 2; p++)
    begin
      if (p == 0)
      begin
        write_protect <= 1'b1;
        // The pin passes two synchroniser stages before status shows it.
        repeat (4) @(posedge sys_clk);
      end
      else
      begin
        av(1'b1, REG_CTRL, 32'h1, r);
        av(1'b0, REG_CTRL, 32'h0, r);
        chk("ctrl readback", 1, r);
      end
      av(1'b0, REG_STATUS, 32'h0, r);
      chk("protect pin", p == 0, r[STATUS_WP]);
      wr(32, 2, 1'b1);
      dev(1'b0, sel, k);
      m.stop();
      chk("no program after refusal", 1, k);
      write_protect <= 1'b0;
      av(1'b1, REG_CTRL, 32'h0, r);
      rd(32, 2, 1'b0);
    end
    finish_test();
  end
  initial
  begin
    #500_000;
    err_total++;
    finish_test();
  end
endmodule : serial_eeprom_bus_slave_bench
